// ==== design/cciv_defs.svh ====
`ifndef CCIV_DEFS_SVH
`define CCIV_DEFS_SVH
`define CCIV_NUM_CH 4
`define CCIV_CH_W 2
`define CCIV_VEC_W 8
`define CCIV_USER_LSB 3
`define CCIV_CODE_LSB 1
`define CCIV_CTL_BIT 0
`define CCIV_VEC_RESET 8'h00
`define CCIV_BASE_RESET 8'h00
// host side software registers, byte offsets
`define CCIV_REG_CMD 4'h0
`define CCIV_REG_STATUS 4'h1
`define CCIV_REG_MASK 4'h2
`define CCIV_REG_BASE 4'h3
`define CCIV_REG_PTR_LO 4'h4
`define CCIV_REG_PTR_HI 4'h5
`define CCIV_REG_DATA 4'h6
// command register fields
`define CCIV_CMD_WRITE 2'h1
`define CCIV_CMD_ACK 2'h2
`define CCIV_CMD_OP_LSB 6
`define CCIV_CMD_CH_LSB 0
`endif

// ==== design/cciv_device.sv ====
`timescale 1ns/100ps
`include "cciv_defs.svh"
module cciv_device import cciv_pkg::*; (
  input wire logic clk, // system clock
  input wire logic arst_n, // async reset, active low
  cciv_link.dev link, // host bus side
  input wire logic [3:0] chan_event, // one-cycle event per channel
  output logic [7:0] vector_base, // stored vector register
  output logic [3:0] ctrl_seen // control word write pulse per channel
);
  logic [3:0] pending;
  logic [1:0] next_code;
  logic wr_vec;

  function automatic logic [1:0] cciv_prio(input logic [3:0] req);
    cciv_prio = 2'h3;
    for (int i = 3; i >= 0; i--) begin
      if (req[i]) begin
        cciv_prio = 2'(i);
      end
    end
  endfunction

  assign wr_vec = link.wr_strobe && link.wr_channel == 2'h0
    && !link.wr_data[`CCIV_CTL_BIT];
  assign next_code = cciv_prio(pending);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      vector_base <= `CCIV_VEC_RESET;
    end else if (wr_vec) begin
      // only the user bits survive a load
      vector_base <= {link.wr_data[7:3], 3'h0};
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_seen <= 4'h0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        ctrl_seen[i] <= link.wr_strobe && link.wr_channel == 2'(i)
          && link.wr_data[`CCIV_CTL_BIT];
      end
    end
  end

  // new event wins over the clear by acknowledge
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pending <= 4'h0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (chan_event[i]) begin
          pending[i] <= 1'b1;
        end else if (link.ack && pending != 4'h0 && next_code == 2'(i)) begin
          pending[i] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      link.vec_valid <= 1'b0;
      link.vec_data <= 8'h00;
    end else begin
      link.vec_valid <= link.ack && pending != 4'h0;
      if (link.ack && pending != 4'h0) begin
        link.vec_data <= {vector_base[7:3], next_code, 1'b0};
      end
    end
  end

  assign link.irq_req = pending;
endmodule // cciv_device

// ==== design/cciv_host.sv ====
`timescale 1ns/100ps
`include "cciv_defs.svh"
module cciv_host import cciv_pkg::*; (
  input wire logic clk, // system clock
  input wire logic arst_n, // async reset, active low
  cciv_link.host link, // device side
  input wire logic [3:0] addr, // register address
  input wire logic [7:0] wdata, // write data
  input wire logic wr, // write strobe
  input wire logic rd, // read strobe
  output logic [7:0] rdata, // read data, cycle after rd
  output logic irq // level interrupt
);
  cciv_host_state_type state;
  logic [7:0] data_reg, base_reg, ptr_lo;
  logic [1:0] status, mask;
  logic busy;

  // cmd: op in 7:6 (1 write, 2 ack), channel in 1:0
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      data_reg <= 8'h00;
      base_reg <= `CCIV_BASE_RESET;
    end else if (wr && addr == `CCIV_REG_DATA) begin
      data_reg <= wdata;
    end else if (wr && addr == `CCIV_REG_BASE) begin
      base_reg <= wdata;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      link.wr_strobe <= 1'b0;
      link.wr_channel <= 2'h0;
      link.wr_data <= 8'h00;
    end else begin
      link.wr_strobe <= wr && addr == `CCIV_REG_CMD && wdata[7:6] == `CCIV_CMD_WRITE;
      if (wr && addr == `CCIV_REG_CMD) begin
        link.wr_channel <= wdata[1:0];
        link.wr_data <= data_reg;
      end
    end
  end

  // one acknowledge at a time; a vector arrives the cycle after ack
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= CCIV_IDLE;
      link.ack <= 1'b0;
      ptr_lo <= 8'h00;
    end else begin
      case (state)
        CCIV_IDLE: begin
          if (wr && addr == `CCIV_REG_CMD && wdata[7:6] == `CCIV_CMD_ACK) begin
            link.ack <= 1'b1;
            state <= CCIV_ACK;
          end
        end
        CCIV_ACK: begin
          link.ack <= 1'b0;
          state <= CCIV_DONE;
        end
        CCIV_DONE: begin
          if (link.vec_valid) begin
            ptr_lo <= link.vec_data;
          end
          state <= CCIV_IDLE;
        end
        default: begin
          state <= CCIV_IDLE;
          link.ack <= 1'b0;
        end
      endcase
    end
  end
  assign busy = state != CCIV_IDLE;

  // status bit0: vector taken, bit1: any request; read clears, set wins
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      status <= 2'h0;
    end else begin
      status[0] <= (state == CCIV_DONE && link.vec_valid)
        || (status[0] && !(rd && addr == `CCIV_REG_STATUS));
      status[1] <= (link.irq_req != 4'h0)
        || (status[1] && !(rd && addr == `CCIV_REG_STATUS));
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mask <= 2'h0;
    end else if (wr && addr == `CCIV_REG_MASK) begin
      mask <= wdata[1:0];
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= (status & mask) != 2'h0;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata <= 8'h00;
    end else if (rd) begin
      case (addr)
        `CCIV_REG_STATUS: rdata <= {busy, 5'h00, status};
        `CCIV_REG_MASK: rdata <= {6'h00, mask};
        `CCIV_REG_BASE: rdata <= base_reg;
        `CCIV_REG_PTR_LO: rdata <= ptr_lo;
        `CCIV_REG_PTR_HI: rdata <= base_reg;
        `CCIV_REG_DATA: rdata <= data_reg;
        default: rdata <= 8'h00;
      endcase
    end else begin
      rdata <= 8'h00;
    end
  end
endmodule // cciv_host

// ==== design/cciv_link.sv ====
`timescale 1ns/100ps
interface cciv_link (
  input wire logic clk, // system clock
  input wire logic arst_n // async reset, active low
);
  logic wr_strobe;
  logic [1:0] wr_channel;
  logic [7:0] wr_data;
  logic [3:0] irq_req;
  logic ack;
  logic vec_valid;
  logic [7:0] vec_data;
  modport dev (input wr_strobe, input wr_channel, input wr_data, output irq_req,
    input ack, output vec_valid, output vec_data);
  modport host (output wr_strobe, output wr_channel, output wr_data, input irq_req,
    output ack, input vec_valid, input vec_data);
endinterface // cciv_link

// ==== design/cciv_pkg.sv ====
package cciv_pkg;
  typedef enum logic [2:0] {
    CCIV_IDLE = 3'b001,
    CCIV_ACK = 3'b010,
    CCIV_DONE = 3'b100
  } cciv_host_state_type;
endpackage

// ==== tb/cciv_bench.sv ====
`timescale 1ns/100ps
`include "cciv_defs.svh"
module cciv_bench import cciv_pkg::*;;
  logic clk = 1'b0, arst_n = 1'b0, wr = 1'b0, rd = 1'b0, irq, i1, i0;
  logic [3:0] addr = 4'h0, ev = 4'h0, seen, acc = 4'h0;
  logic [7:0] wdata = 8'h00, rdata, base;
  int fails = 0, tests_run = 0;
  cciv_link link (.clk(clk), .arst_n(arst_n));
  cciv_device i_cciv_device (.clk(clk), .arst_n(arst_n), .link(link), .chan_event(ev),
    .vector_base(base), .ctrl_seen(seen));
  cciv_host i_cciv_host (.clk(clk), .arst_n(arst_n), .link(link), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .irq(irq));
  cciv_props i_cciv_props (.clk(clk), .arst_n(arst_n), .wr_strobe(link.wr_strobe),
    .wr_channel(link.wr_channel), .wr_data(link.wr_data), .irq_req(link.irq_req),
    .ack(link.ack), .vec_valid(link.vec_valid), .vec_data(link.vec_data));
  initial forever #25 clk = ~clk;
  always @(posedge clk) acc <= acc | seen;
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    tests_run++;
    if (g !== e) begin
      fails++;
      $display("BAD %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic write_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic read_reg(input logic [3:0] a, input logic [7:0] e, input logic [7:0] m);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(rdata & m, e);
  endtask
  task automatic load(input logic [7:0] ch, input logic [7:0] d);
    write_reg(`CCIV_REG_DATA, d);
    write_reg(`CCIV_REG_CMD, 8'h40 | ch);
    repeat (3) @(posedge clk);
  endtask
  task automatic ack_vec();
    write_reg(`CCIV_REG_CMD, 8'h80);
    repeat (4) @(posedge clk);
  endtask
  task automatic pulse(input logic [3:0] e);
    @(posedge clk) ev <= e;
    @(posedge clk) ev <= 4'h0;
  endtask
  task automatic finish_test();
    $display("tests %0d fails %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (3000) @(posedge clk);
    fails++;
    finish_test();
  end
  initial begin
    repeat (12) @(posedge clk);
    arst_n <= 1'b1;
    load(8'h0, 8'hAE);
    chk(base, 8'hA8);
    load(8'h0, 8'h51);
    load(8'h2, 8'h57);
    chk(base, 8'hA8);
    chk({4'h0, acc}, 8'h05);
    write_reg(`CCIV_REG_BASE, 8'h12);
    read_reg(`CCIV_REG_PTR_HI, 8'h12, 8'hFF);
    read_reg(4'hF, 8'h00, 8'hFF);
    read_reg(`CCIV_REG_STATUS, 8'h00, 8'hFF);
    pulse(4'hF);
    for (int i = 0; i < 4; i++) begin
      ack_vec();
      read_reg(`CCIV_REG_PTR_LO, 8'hA8 | 8'(2 * i), 8'hFF);
    end
    read_reg(`CCIV_REG_STATUS, 8'h03, 8'hFF);
    pulse(4'h2);
    read_reg(`CCIV_REG_STATUS, 8'h02, 8'hFF);
    ack_vec();
    read_reg(`CCIV_REG_PTR_LO, 8'hAA, 8'hFF);
    write_reg(`CCIV_REG_MASK, 8'h03);
    repeat (2) @(posedge clk) i1 = irq;
    write_reg(`CCIV_REG_MASK, 8'h00);
    repeat (2) @(posedge clk) i0 = irq;
    chk({6'h00, i1, i0}, 8'h02);
    read_reg(`CCIV_REG_STATUS, 8'h03, 8'hFF);
    write_reg(`CCIV_REG_MASK, 8'h03);
    repeat (2) @(posedge clk);
    chk({7'h0, irq}, 8'h00);
    ack_vec();
    read_reg(`CCIV_REG_STATUS, 8'h00, 8'hFF);
    read_reg(`CCIV_REG_PTR_LO, 8'hAA, 8'hFF);
    finish_test();
  end
endmodule // cciv_bench

// ==== tb/cciv_props.sv ====
`timescale 1ns/100ps
module cciv_props (
  input wire logic clk, // clock
  input wire logic arst_n, // reset
  input wire logic wr_strobe, // write
  input wire logic [1:0] wr_channel, // channel
  input wire logic [7:0] wr_data, // byte
  input wire logic [3:0] irq_req, // pending
  input wire logic ack, // acknowledge
  input wire logic vec_valid, // vector pulse
  input wire logic [7:0] vec_data // vector
);
  logic [4:0] usr;
  logic [1:0] win;
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  always_comb win = irq_req[0] ? 2'h0 : irq_req[1] ? 2'h1 : irq_req[2] ? 2'h2 : 2'h3;
  // control words and bits 2:1 never reach this copy
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) usr <= 5'h00;
    else if (wr_strobe && wr_channel == 2'h0 && !wr_data[0]) usr <= wr_data[7:3];
  end
  ack_answer_a: assert property (ack && irq_req != 4'h0 |=> vec_valid)
    else $error("no vector");
  only_on_ack_a: assert property (vec_valid |-> $past(ack) && $past(irq_req) != 4'h0)
    else $error("stray vector");
  no_pending_a: assert property (ack && irq_req == 4'h0 |=> !vec_valid)
    else $error("vector unasked");
  chan_code_a: assert property (ack && irq_req != 4'h0 |=> vec_data[2:1] == $past(win))
    else $error("bad code");
  user_bits_a: assert property (vec_valid |-> vec_data[7:3] == usr)
    else $error("bad user bits");
  even_entry_a: assert property (vec_valid |-> !vec_data[0])
    else $error("odd vector");
  ack_pulse_a: assert property (ack |=> !ack)
    else $error("long ack");
  pend_hold_a: assert property (($past(irq_req) & ~irq_req) != 4'h0 |-> $past(ack))
    else $error("pending lost");
  cover property (ack && irq_req[3] && irq_req[0]);
  cover property (vec_valid && vec_data[2:1] == 2'h3);
  cover property (wr_strobe && wr_data[0]);
endmodule // cciv_props
